// ==== logic/mcr_pkg.sv ====
// Constants, field layouts and types for the monitor control register bank.
// Assumes a 2-wire serial front end that hands over decoded byte accesses.
//
// Behaviour
// - Finished conversion sets that parameter's fresh flag
// - Reading a result register clears its flag
// - Fresh flags bits 7..3: temp, supply, bias, tx, rx
// - Bias select 00/01/10 picks setpoint; 11 reserved
// - Modulation select 00/01/10 picks setpoint; 11 reserved
// - No interrupt unless global enable is set
// - Masked-in power-on raises interrupt; warm reset never
// - Power-on interrupt sets the power-on flag
// - Reading user control clears flag and interrupt
// - Writing enable one while asserted releases interrupt
// - Late mask keeps flag and interrupt until read
// - Mask, enable, bias select are nonvolatile
// - User password for control, OEM for config zero
// - User control at 255, or 222 when bit set
// - Config zero write aborts conversion, then restarts
// - Config zero nonvolatile except fault and reset bits
// - Writing reset bit one triggers warm reset; write-only
// - Zone bit: 0 internal, 1 external sensor
// - Diode fault bit reports fault; writes cannot set
// - Output enable drives outputs; reference select ground/supply
// - Voltage select codes 000..110 route monitored voltage
package mcr_pkg;

   // ------------------------------------------------------------
   // Serial and byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] MCR_SA_USER = 8'hA2;      // User page device select
   localparam logic [7:0] MCR_SA_OEM = 8'hA6;       // OEM page device select
   localparam logic [7:0] MCR_ADDR_OCFG = 8'h00;    // Config register zero
   localparam logic [7:0] MCR_ADDR_UCTL = 8'hFF;    // User control, normal place
   localparam logic [7:0] MCR_ADDR_UCTL_ALT = 8'hDE; // User control, moved place
   localparam logic [7:0] MCR_ADDR_FRESH = 8'hFD;   // Fresh flags
   // Result high bytes on the user page; index 4 is temperature, 0 receive power
   localparam logic [4:0][7:0] MCR_RES_ADDR = {8'h60, 8'h62, 8'h64, 8'h66, 8'h68};

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int MCR_UC_PWRON_MASK = 6; // Power-on interrupt mask
   localparam int MCR_UC_PWRON_FLAG = 5; // Power-on interrupt flag
   localparam int MCR_UC_IRQ_EN = 4; // Global interrupt enable
   localparam int MCR_UC_BIAS = 2;   // Bias select, low bit
   localparam int MCR_UC_MOD = 0;    // Modulation select, low bit
   localparam int MCR_OC_RST = 7;    // Warm reset, write-only
   localparam int MCR_OC_ZONE = 6;   // Temperature zone
   localparam int MCR_OC_FAULT = 5; // Diode fault, read-only
   localparam int MCR_OC_OE = 4;     // Output enable
   localparam int MCR_OC_MOD_REF = 3; // Modulation reference
   localparam int MCR_OC_VSEL = 0;   // Voltage select, low bit
   localparam int MCR_FR_LOW = 3;    // Lowest fresh flag bit

   // ------------------------------------------------------------
   // Reset values and codes
   // ------------------------------------------------------------
   localparam logic [7:0] MCR_UCTL_RESET = 8'h20;
   localparam logic [7:0] MCR_OCFG_RESET = 8'h00;
   localparam logic [4:0] MCR_FRESH_RESET = 5'h00;
   localparam logic [1:0] MCR_SEL_RESERVED = 2'h3;
   localparam logic [2:0] MCR_VSEL_LAST = 3'h6;

   // Power-up phase: one cycle to load nonvolatile copies, then normal running
   typedef enum logic {MCR_BOOT, MCR_RUN} mcr_phase_e;

endpackage

// ==== logic/mcr_fresh_if.sv ====
// Interface between the register bank and its fresh flag store.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface mcr_fresh_if;
   logic [4:0] done;   // Conversion finished pulses, bit 4 temperature
   logic [4:0] clear;  // Result read pulses
   logic [4:0] flags;  // Stored fresh flags
   modport store (input done, input clear, output flags);
   modport bank (output done, output clear, input flags);
endinterface

// ==== logic/mcr_fresh_flags.sv ====
// Fresh-result flag store, set by conversions, cleared by result reads.
// Assumes done and clear come from logic on the same clock.
`timescale 1ns/1ps
module mcr_fresh_flags (
   input wire logic clock,
   input wire logic rstn,
   mcr_fresh_if.store fi
);
   // State record
   typedef struct packed {
      logic [4:0] flags;  // One per measured parameter
   } mcr_fresh_s;

   mcr_fresh_s st_ff;
   mcr_fresh_s nxt_st;

   // ------------------------------------------------------------
   // Flag update
   // ------------------------------------------------------------
   // A finish in the same cycle as a read keeps the flag: fresh data must not be lost
   always_comb begin
      nxt_st = st_ff;
      nxt_st.flags = (st_ff.flags & ~fi.clear) | fi.done;
   end

   // Register the record
   always_ff @(posedge clock) begin
      if (!rstn) begin
         st_ff.flags <= mcr_pkg::MCR_FRESH_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign fi.flags = st_ff.flags;

   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   fresh_set_a: assert property (fi.done[4] |=> fi.flags[4])
      else $error("temperature flag not set after finish");
   fresh_clear_a: assert property (fi.clear[0] && !fi.done[0] |=> !fi.flags[0])
      else $error("receive flag not cleared by read");
endmodule

// ==== logic/mcr_bank.sv ====
// Monitor control register bank: user control, config zero and fresh flags.
// Assumes a serial front end delivering byte reads and writes with a device
// select, and nonvolatile copies presented on nv inputs at power-up.
`timescale 1ns/1ps
module mcr_bank (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] sa,
   input wire logic [7:0] addr,
   input wire logic wr_stb,
   input wire logic [7:0] wr_data,
   input wire logic rd_stb,
   output logic [7:0] rd_data,
   input wire logic user_pw_ok,
   input wire logic oem_pw_ok,
   input wire logic uctl_alt_place,
   input wire logic [4:0] conv_done,
   input wire logic alarm_irq_event,
   input wire logic diode_fault_pin,
   input wire logic [7:0] nv_uctl_in,
   input wire logic [7:0] nv_ocfg_in,
   output logic nv_wr,
   output logic [7:0] nv_uctl_out,
   output logic [7:0] nv_ocfg_out,
   output logic irq_n,
   output logic warm_reset,
   output logic conv_abort,
   output logic conv_restart,
   output logic zone_external,
   output logic out_enable,
   output logic modulation_reference_select,
   output logic [2:0] monitor_voltage_select,
   output logic [1:0] bias_setpoint_select,
   output logic [1:0] modulation_setpoint_select
);
   // ------------------------------------------------------------
   // State record
   // ------------------------------------------------------------
   typedef struct packed {
      mcr_pkg::mcr_phase_e phase;
      logic pwron_mask; // Power-on interrupt mask
      logic pwron_flag; // Power-on interrupt flag
      logic irq_en; // Global interrupt enable
      logic [1:0] bias;    // Bias setpoint select
      logic [1:0] mod_sel; // Modulation setpoint select
      logic zone;          // External temperature zone
      logic oe;            // Output enable
      logic mod_ref; // Modulation reference to supply
      logic [2:0] vsel;    // Monitored voltage select
      logic irq_pend;      // Interrupt latch
      logic irq_n;         // Interrupt pin, low active
      logic [7:0] rd_data; // Read answer
      logic warm_reset;    // Warm reset pulse
      logic conv_abort;    // Conversion abort pulse
      logic conv_restart;  // Conversion restart pulse
      logic nv_wr;         // Store nonvolatile copies pulse
      logic fault_meta; // Fault pin, first stage
      logic fault_sync; // Fault pin, second stage
   } mcr_bank_s;

   mcr_bank_s st_ff;
   mcr_bank_s nxt_st;

   // Decoded access terms, also watched by the checks below
   logic run;
   logic wr;
   logic rd;
   logic user_ok;
   logic oem_ok;
   logic uctl_hit;
   logic ocfg_hit;
   logic fresh_hit;
   logic [4:0] res_hit;

   mcr_fresh_if fi ();

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // True for a setpoint select code that names a real register
   function automatic logic mcr_sel_ok(input logic [1:0] code);
      mcr_sel_ok = (code != mcr_pkg::MCR_SEL_RESERVED);
   endfunction

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   assign run = (st_ff.phase == mcr_pkg::MCR_RUN);
   assign wr = wr_stb && run;
   assign rd = rd_stb && run;
   // OEM password overrides the user level
   assign oem_ok = oem_pw_ok;
   assign user_ok = user_pw_ok || oem_pw_ok;
   // User control moves with the placement bit
   assign uctl_hit = (sa == mcr_pkg::MCR_SA_USER) &&
      (addr == (uctl_alt_place ? mcr_pkg::MCR_ADDR_UCTL_ALT : mcr_pkg::MCR_ADDR_UCTL));
   assign ocfg_hit = (sa == mcr_pkg::MCR_SA_OEM) && (addr == mcr_pkg::MCR_ADDR_OCFG);
   assign fresh_hit = (sa == mcr_pkg::MCR_SA_OEM) && (addr == mcr_pkg::MCR_ADDR_FRESH);

   // Result reads clear fresh flags
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         res_hit[i] = (sa == mcr_pkg::MCR_SA_USER) && (addr == mcr_pkg::MCR_RES_ADDR[i]);
      end
   end

   assign fi.done = conv_done;
   assign fi.clear = rd ? res_hit : 5'h00;

   mcr_fresh_flags u_fresh (
      .clock(clock),
      .rstn(rstn),
      .fi(fi)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.rd_data = 8'h00;
      nxt_st.warm_reset = 1'b0;
      nxt_st.conv_abort = 1'b0;
      nxt_st.nv_wr = 1'b0;
      // Restart follows the abort pulse by one cycle
      nxt_st.conv_restart = st_ff.conv_abort;
      // Fault level crosses in from the analog side
      nxt_st.fault_meta = diode_fault_pin;
      nxt_st.fault_sync = st_ff.fault_meta;
      case (st_ff.phase)
         mcr_pkg::MCR_BOOT: begin
            // Nonvolatile copies come back after power-up
            nxt_st.pwron_mask = nv_uctl_in[mcr_pkg::MCR_UC_PWRON_MASK];
            nxt_st.irq_en = nv_uctl_in[mcr_pkg::MCR_UC_IRQ_EN];
            nxt_st.bias = nv_uctl_in[mcr_pkg::MCR_UC_BIAS +: 2];
            nxt_st.mod_sel = nv_uctl_in[mcr_pkg::MCR_UC_MOD +: 2];
            nxt_st.zone = nv_ocfg_in[mcr_pkg::MCR_OC_ZONE];
            nxt_st.oe = nv_ocfg_in[mcr_pkg::MCR_OC_OE];
            nxt_st.mod_ref = nv_ocfg_in[mcr_pkg::MCR_OC_MOD_REF];
            nxt_st.vsel = nv_ocfg_in[mcr_pkg::MCR_OC_VSEL +: 3];
            // The power-on event leaves the flag only when masked in
            nxt_st.pwron_flag = nv_uctl_in[mcr_pkg::MCR_UC_PWRON_MASK];
            nxt_st.irq_pend = nv_uctl_in[mcr_pkg::MCR_UC_PWRON_MASK] &&
               nv_uctl_in[mcr_pkg::MCR_UC_IRQ_EN];
            nxt_st.phase = mcr_pkg::MCR_RUN;
         end
         mcr_pkg::MCR_RUN: begin
            // Read answers; denied or unmapped reads give zero
            if (rd && uctl_hit && user_ok) begin
               // Bit 7 has no meaning to the host and returns zero
               nxt_st.rd_data = {1'b0, st_ff.pwron_mask, st_ff.pwron_flag, st_ff.irq_en,
                  st_ff.bias, st_ff.mod_sel};
               // Reading acknowledges the power-on interrupt
               nxt_st.pwron_flag = 1'b0;
               nxt_st.irq_pend = 1'b0;
            end else if (rd && ocfg_hit && oem_ok) begin
               // Reset bit is write-only and reads zero
               nxt_st.rd_data = {1'b0, st_ff.zone, st_ff.fault_sync, st_ff.oe,
                  st_ff.mod_ref, st_ff.vsel};
            end else if (rd && fresh_hit) begin
               nxt_st.rd_data = {fi.flags, 3'h0};
            end
            // User control write; the flag bit is read-only
            if (wr && uctl_hit && user_ok) begin
               nxt_st.pwron_mask = wr_data[mcr_pkg::MCR_UC_PWRON_MASK];
               nxt_st.irq_en = wr_data[mcr_pkg::MCR_UC_IRQ_EN];
               // Reserved codes are refused so the pick stays valid
               if (mcr_sel_ok(wr_data[mcr_pkg::MCR_UC_BIAS +: 2])) begin
                  nxt_st.bias = wr_data[mcr_pkg::MCR_UC_BIAS +: 2];
               end
               if (mcr_sel_ok(wr_data[mcr_pkg::MCR_UC_MOD +: 2])) begin
                  nxt_st.mod_sel = wr_data[mcr_pkg::MCR_UC_MOD +: 2];
               end
               // Setting enable while the pin is low releases it
               if (wr_data[mcr_pkg::MCR_UC_IRQ_EN] && !st_ff.irq_n) begin
                  nxt_st.irq_pend = 1'b0;
               end
               // A late mask does not touch flag or latch
               nxt_st.nv_wr = 1'b1;
            end
            // Config zero write; the fault bit cannot be written
            if (wr && ocfg_hit && oem_ok) begin
               nxt_st.zone = wr_data[mcr_pkg::MCR_OC_ZONE];
               nxt_st.oe = wr_data[mcr_pkg::MCR_OC_OE];
               nxt_st.mod_ref = wr_data[mcr_pkg::MCR_OC_MOD_REF];
               // Codes past the last source are refused
               if (wr_data[mcr_pkg::MCR_OC_VSEL +: 3] <= mcr_pkg::MCR_VSEL_LAST) begin
                  nxt_st.vsel = wr_data[mcr_pkg::MCR_OC_VSEL +: 3];
               end
               // Warm reset is a pulse only; it never raises the power-on flag
               nxt_st.warm_reset = wr_data[mcr_pkg::MCR_OC_RST];
               nxt_st.conv_abort = 1'b1;
               nxt_st.nv_wr = 1'b1;
            end
            // Other status events; a set beats a same-cycle release
            if (alarm_irq_event && nxt_st.irq_en) begin
               nxt_st.irq_pend = 1'b1;
            end
         end
         default: begin
            nxt_st.phase = mcr_pkg::MCR_BOOT;
         end
      endcase
      // Pin is held off whenever enable is clear
      nxt_st.irq_n = !(nxt_st.irq_pend && nxt_st.irq_en);
   end

   // ------------------------------------------------------------
   // Register the record
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rstn) begin
         st_ff <= '0;
         st_ff.phase <= mcr_pkg::MCR_BOOT;
         st_ff.pwron_flag <= mcr_pkg::MCR_UCTL_RESET[mcr_pkg::MCR_UC_PWRON_FLAG];
         st_ff.zone <= mcr_pkg::MCR_OCFG_RESET[mcr_pkg::MCR_OC_ZONE];
         st_ff.irq_n <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign rd_data = st_ff.rd_data;
   assign nv_wr = st_ff.nv_wr;
   // Volatile bits go out as zero so a boot never restores them
   assign nv_uctl_out = {1'b0, st_ff.pwron_mask, 1'b0, st_ff.irq_en,
      st_ff.bias, st_ff.mod_sel};
   assign nv_ocfg_out = {1'b0, st_ff.zone, 1'b0, st_ff.oe, st_ff.mod_ref, st_ff.vsel};
   assign irq_n = st_ff.irq_n;
   assign warm_reset = st_ff.warm_reset;
   assign conv_abort = st_ff.conv_abort;
   assign conv_restart = st_ff.conv_restart;
   assign zone_external = st_ff.zone;
   assign out_enable = st_ff.oe;
   assign modulation_reference_select = st_ff.mod_ref;
   assign monitor_voltage_select = st_ff.vsel;
   assign bias_setpoint_select = st_ff.bias;
   assign modulation_setpoint_select = st_ff.mod_sel;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence ocfg_write_s;
      wr && ocfg_hit && oem_ok;
   endsequence
   sequence abort_restart_s;
      conv_abort && !conv_restart ##1 conv_restart && !conv_abort;
   endsequence

   fresh_layout_a: assert property (rd && fresh_hit |=>
      rd_data == {$past(fi.flags), 3'h0})
      else $error("fresh flag read layout wrong");
   bias_reserved_a: assert property (wr && uctl_hit && user_ok &&
      wr_data[3:2] == 2'h3 |=> $stable(bias_setpoint_select))
      else $error("reserved bias code was taken");
   mod_reserved_a: assert property (wr && uctl_hit && user_ok &&
      wr_data[1:0] == 2'h3 |=> $stable(modulation_setpoint_select))
      else $error("reserved modulation code was taken");
   irq_gate_a: assert property (!irq_n |-> st_ff.irq_en)
      else $error("interrupt without global enable");
   por_flag_a: assert property (st_ff.phase == mcr_pkg::MCR_BOOT |=>
      st_ff.pwron_flag == $past(nv_uctl_in[6]))
      else $error("power-on flag does not follow mask");
   uctl_ack_a: assert property (rd && uctl_hit && user_ok && !alarm_irq_event
      |=> !st_ff.pwron_flag && irq_n)
      else $error("user control read did not acknowledge");
   enable_release_a: assert property (wr && uctl_hit && user_ok && wr_data[4] &&
      !irq_n && !alarm_irq_event |=> irq_n)
      else $error("enable write did not release pin");
   // The boot cycle may legally drop the reset value of the flag
   flag_hold_a: assert property (run && st_ff.pwron_flag && !(rd && uctl_hit && user_ok)
      |=> st_ff.pwron_flag)
      else $error("power-on flag dropped without read");
   pw_guard_a: assert property (wr && uctl_hit && !user_ok |=>
      $stable(st_ff.irq_en) && $stable(st_ff.pwron_mask))
      else $error("user control written without password");
   ocfg_abort_a: assert property (ocfg_write_s |=> abort_restart_s)
      else $error("config write did not abort and restart");
   warm_pulse_a: assert property (ocfg_write_s ##0 wr_data[7] |=>
      warm_reset ##1 !warm_reset)
      else $error("warm reset pulse wrong");

   // ------------------------------------------------------------
   // Config zero field checks
   // ------------------------------------------------------------
   // Fields must follow the written byte one cycle after the write
   zone_follow_a: assert property (ocfg_write_s |=>
      zone_external == $past(wr_data[mcr_pkg::MCR_OC_ZONE]))
      else $error("zone bit did not follow write");
   oe_follow_a: assert property (ocfg_write_s |=>
      out_enable == $past(wr_data[mcr_pkg::MCR_OC_OE]))
      else $error("output enable did not follow write");
   // The unused voltage code would leave the monitor routed nowhere
   vsel_reserved_a: assert property (ocfg_write_s ##0 wr_data[2:0] == 3'h7 |=>
      $stable(monitor_voltage_select))
      else $error("unused voltage code was taken");
   // Fault bit comes from the synchroniser, never from the host
   fault_read_a: assert property (rd && ocfg_hit && oem_ok |=>
      rd_data[mcr_pkg::MCR_OC_FAULT] == $past(st_ff.fault_sync))
      else $error("fault bit read wrong");
   cfg_deny_a: assert property (rd && ocfg_hit && !oem_ok |=> rd_data == 8'h00)
      else $error("config read without password not zero");
   // A warm reset must never look like a power-on event
   warm_no_por_a: assert property (warm_reset && !st_ff.pwron_flag |=>
      !st_ff.pwron_flag)
      else $error("warm reset raised power-on flag");
endmodule

// ==== verification/mcr_nv_model.sv ====
// Nonvolatile store model standing behind the bank's nv ports.
// Assumes the bank's clock; images persist across bank resets.
`timescale 1ns/1ps
module mcr_nv_model (
   input wire logic clock,
   input wire logic nv_wr,
   input wire logic [7:0] uctl_w,
   input wire logic [7:0] ocfg_w,
   output logic [7:0] uctl_r,
   output logic [7:0] ocfg_r
);
   // Factory image: mask and enable set, so power-on interrupts
   initial begin
      uctl_r = 8'h50;
      ocfg_r = 8'h00;
   end
   // Store on the write pulse only; a reset of the bank never reaches here
   always @(posedge clock) begin
      if (nv_wr) begin
         uctl_r <= uctl_w;
         ocfg_r <= ocfg_w;
      end
   end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the monitor control register bank.
// Assumes decoded byte accesses; inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
module tb_top;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] sa = 8'h00, addr = 8'h00, wr_data = 8'h00, rd_data, rv, r;
   logic wr_stb = 1'b0, rd_stb = 1'b0, user_pw_ok = 1'b1, oem_pw_ok = 1'b1;
   logic uctl_alt_place = 1'b0, alarm_irq_event = 1'b0, diode_fault_pin = 1'b0;
   logic [4:0] conv_done = 5'h00, mf;
   logic [7:0] nv_uctl_in, nv_ocfg_in, nv_uctl_out, nv_ocfg_out, muc, mo;
   logic nv_wr, irq_n, warm_reset, conv_abort, conv_restart, zone_external, out_enable, mref;
   logic [2:0] vsel;
   logic [1:0] bsel, msel;
   logic [15:0] seed = 16'h8A3F; // Fixed start keeps runs repeatable
   int err_count = 0, checks_done = 0, cyc = 0, i;
   mcr_bank mcr_bank_inst (.clock(clock), .rstn(rstn), .sa(sa), .addr(addr),
      .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb), .rd_data(rd_data),
      .user_pw_ok(user_pw_ok), .oem_pw_ok(oem_pw_ok), .uctl_alt_place(uctl_alt_place),
      .conv_done(conv_done), .alarm_irq_event(alarm_irq_event),
      .diode_fault_pin(diode_fault_pin), .nv_uctl_in(nv_uctl_in), .nv_ocfg_in(nv_ocfg_in),
      .nv_wr(nv_wr), .nv_uctl_out(nv_uctl_out), .nv_ocfg_out(nv_ocfg_out), .irq_n(irq_n),
      .warm_reset(warm_reset), .conv_abort(conv_abort), .conv_restart(conv_restart),
      .zone_external(zone_external), .out_enable(out_enable),
      .modulation_reference_select(mref), .monitor_voltage_select(vsel),
      .bias_setpoint_select(bsel), .modulation_setpoint_select(msel));
   mcr_nv_model mcr_nv_model_inst (.clock(clock), .nv_wr(nv_wr), .uctl_w(nv_uctl_out),
      .ocfg_w(nv_ocfg_out), .uctl_r(nv_uctl_in), .ocfg_r(nv_ocfg_in));
   // ------------------------------------------------------------
   // Clock, timeout and helpers
   // ------------------------------------------------------------
   always #5 clock = ~clock;
   // Whole run is well under 1000 cycles; a hang ends here
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         end_sim();
      end
   end
   function automatic logic [7:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed[7:0];
   endfunction
   // Reserved select codes keep the old field; flag bit is never written
   function automatic logic [7:0] uc_upd(input logic [7:0] o, input logic [7:0] w);
      return {1'b0, w[6], o[5], w[4], (w[3:2] == 2'h3) ? o[3:2] : w[3:2],
         (w[1:0] == 2'h3) ? o[1:0] : w[1:0]};
   endfunction
   function automatic logic [7:0] oc_upd(input logic [7:0] o, input logic [7:0] w);
      return {1'b0, w[6], 1'b0, w[4:3], (w[2:0] == 3'h7) ? o[2:0] : w[2:0]};
   endfunction
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   // One byte access; strobe held for exactly one sampling edge
   task automatic acc(input logic w, input logic [7:0] s, input logic [7:0] a,
      input logic [7:0] v);
      @(posedge clock) #1;
      sa = s;
      addr = a;
      wr_data = v;
      wr_stb = w;
      rd_stb = !w;
      @(posedge clock) #1;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      rv = rd_data;
   endtask
   task automatic ruc();
      acc(1'b0, mcr_pkg::MCR_SA_USER, mcr_pkg::MCR_ADDR_UCTL, 8'h00);
   endtask
   task automatic wuc(input logic [7:0] v);
      acc(1'b1, mcr_pkg::MCR_SA_USER, mcr_pkg::MCR_ADDR_UCTL, v);
      if (user_pw_ok || oem_pw_ok) muc = uc_upd(muc, v);
   endtask
   task automatic rcf();
      acc(1'b0, mcr_pkg::MCR_SA_OEM, mcr_pkg::MCR_ADDR_OCFG, 8'h00);
   endtask
   task automatic rfr();
      acc(1'b0, mcr_pkg::MCR_SA_OEM, mcr_pkg::MCR_ADDR_FRESH, 8'h00);
   endtask
   // Config write plus its pulses and the restart one cycle later
   task automatic wcf(input logic [7:0] v);
      acc(1'b1, mcr_pkg::MCR_SA_OEM, mcr_pkg::MCR_ADDR_OCFG, v);
      mo = oc_upd(mo, v);
      chk("cfg_pulse", {5'h00, v[7], 2'h3}, {5'h00, warm_reset, conv_abort, nv_wr});
      chk("cfg_out", mo, {1'b0, zone_external, 1'b0, out_enable, mref, vsel});
      @(posedge clock) #1;
      chk("restart", 8'h01, {5'h00, warm_reset, conv_abort, conv_restart});
   endtask
   task automatic pulse_alarm();
      @(posedge clock) #1 alarm_irq_event = 1'b1;
      @(posedge clock) #1 alarm_irq_event = 1'b0;
      repeat (2) @(posedge clock);
      #1;
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clock);
      #1 rstn = 1'b1;
      muc = 8'h70;
      mo = 8'h00;
      mf = 5'h00;
      @(posedge clock) #1;
      chk("irq_boot", 8'h00, {7'h00, irq_n});
      ruc();
      chk("uctl_por", muc, rv);
      muc[5] = 1'b0;
      chk("irq_ack", 8'h01, {7'h00, irq_n});
      $display("test power-on done");
      // Locked out: writes ignored, reads give zero
      user_pw_ok = 1'b0;
      oem_pw_ok = 1'b0;
      wuc(8'h00);
      ruc();
      chk("uctl_locked", 8'h00, rv);
      user_pw_ok = 1'b1;
      acc(1'b1, mcr_pkg::MCR_SA_OEM, mcr_pkg::MCR_ADDR_OCFG, 8'h1F);
      rcf();
      chk("cfg_locked", 8'h00, rv);
      ruc();
      chk("uctl_kept", muc, rv);
      oem_pw_ok = 1'b1;
      $display("test password done");
      // Every select code, reserved ones included; bit 7 always written 0
      for (int k = 0; k < 8; k++) begin
         r = rnd();
         wuc({2'h1, r[5], 1'b1, k[1:0], k[2:1]});
         chk("sel_out", {4'h0, muc[3:0]}, {4'h0, bsel, msel});
         ruc();
         chk("uctl_rd", muc, rv);
      end
      uctl_alt_place = 1'b1;
      acc(1'b0, mcr_pkg::MCR_SA_USER, mcr_pkg::MCR_ADDR_UCTL_ALT, 8'h00);
      chk("uctl_alt", muc, rv);
      ruc();
      chk("uctl_moved", 8'h00, rv);
      uctl_alt_place = 1'b0;
      $display("test selects done");
      // Random config values; first one carries the unused voltage code
      for (int k = 0; k < 8; k++) begin
         r = rnd();
         wcf((k == 0) ? (r | 8'h07) : r);
         rcf();
         chk("cfg_rd", mo, rv);
         chk("irq_warm", 8'h01, {7'h00, irq_n});
      end
      $display("test config done");
      pulse_alarm();
      chk("irq_alarm", 8'h00, {7'h00, irq_n});
      wuc(muc);
      chk("irq_ie_wr", 8'h01, {7'h00, irq_n});
      $display("test interrupt done");
      acc(1'b1, mcr_pkg::MCR_SA_OEM, mcr_pkg::MCR_ADDR_FRESH, 8'hFF);
      for (int k = 0; k < 5; k++) begin
         r = rnd();
         @(posedge clock) #1 conv_done = r[4:0];
         @(posedge clock) #1 conv_done = 5'h00;
         mf = mf | r[4:0];
         rfr();
         chk("fresh_set", {mf, 3'h0}, rv);
         i = k;
         acc(1'b0, mcr_pkg::MCR_SA_USER, mcr_pkg::MCR_RES_ADDR[i], 8'h00);
         mf[i] = 1'b0;
         rfr();
         chk("fresh_clr", {mf, 3'h0}, rv);
      end
      $display("test fresh done");
      diode_fault_pin = 1'b1;
      repeat (3) @(posedge clock);
      rcf();
      chk("fault_rd", mo | 8'h20, rv);
      diode_fault_pin = 1'b0;
      repeat (3) @(posedge clock);
      wcf(mo | 8'h20);
      rcf();
      chk("fault_wr", mo, rv);
      $display("test fault done");
      // Mid-run reset: stored images come back at boot
      @(posedge clock) #1 rstn = 1'b0;
      @(posedge clock) #1 rstn = 1'b1;
      @(posedge clock) #1;
      chk("sel_boot", {4'h0, muc[3:0]}, {4'h0, bsel, msel});
      muc[5] = 1'b1;
      ruc();
      chk("uctl_boot", muc, rv);
      muc[5] = 1'b0;
      rcf();
      chk("cfg_boot", mo, rv);
      // Enable off: an event must not reach the pin
      wuc({2'h1, 2'h0, muc[3:0]});
      pulse_alarm();
      chk("irq_off", 8'h01, {7'h00, irq_n});
      $display("test reset and enable done");
      end_sim();
   end
endmodule
